// file: cssx_consts.vh
// Shared constants for the skip / subtract / swap / xor / table-read core.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef CSSX_CONSTS_VH
`define CSSX_CONSTS_VH

// Operation codes presented on op_code_i
`define CSSX_OP_W 4
`define CSSX_OP_INCR_SKIP_ZERO 4'h0
`define CSSX_OP_INCR_TO_A_SKIP 4'h1
`define CSSX_OP_BIT_SET_SKIP 4'h2
`define CSSX_OP_SUB_MEM 4'h3
`define CSSX_OP_MINUS_TO_MEMORY 4'h4
`define CSSX_OP_SUB_IMM 4'h5
`define CSSX_OP_NIBBLE_FLIP 4'h6
`define CSSX_OP_NIBBLE_FLIP_TO_A 4'h7
`define CSSX_OP_ZERO_SKIP 4'h8
`define CSSX_OP_MOVE_SKIP_ZERO 4'h9
`define CSSX_OP_BIT_CLEAR_SKIP 4'hA
`define CSSX_OP_TABLE_READ_CUR_PAGE 4'hB
`define CSSX_OP_TABLE_READ_LAST_PAGE 4'hC
`define CSSX_OP_XOR_MEM 4'hD
`define CSSX_OP_EXCLUSIVE_OR_TO_MEM 4'hE
`define CSSX_OP_XOR_IMM 4'hF

// Data path widths and fields
`define CSSX_DW 8
`define CSSX_LO_NIB 3:0
`define CSSX_HI_NIB 7:4
`define CSSX_NIB_W 4
`define CSSX_TAB_LO 7:0
`define CSSX_TAB_HI 13:8
`define CSSX_ZERO_BYTE 8'h00
`define CSSX_ONE_BIT 1'b1

// Reset values
`define CSSX_ACC_RST 8'h00
`define CSSX_FLAG_RST 1'b0
`define CSSX_TABLE_HIGH_RST 6'h00

// Machine state codes
`define CSSX_ST_W 2
`define CSSX_ST_EXEC 2'h0
`define CSSX_ST_DUMMY 2'h1
`define CSSX_ST_TABLE 2'h2

`endif

// file: cssx_alu.v
// Eight-bit adder with carry in, giving carry, nibble carry and signed overflow.
// Assumes the caller pre-inverts the subtrahend and forces carry in for subtracts.
`timescale 1ns/1ns
`default_nettype none
`include "cssx_consts.vh"

module cssx_alu (
    input wire [`CSSX_DW-1:0] a_i,
    input wire [`CSSX_DW-1:0] b_i,
    input wire cin_i,
    output wire [`CSSX_DW-1:0] sum_o,
    output wire c_o,
    output wire ac_o,
    output wire ovf_o
);
    // Low nibble sum, one spare bit for the nibble carry
    wire [`CSSX_NIB_W:0] nib_sum;
    // Full sum, one spare bit for the byte carry
    wire [`CSSX_DW:0] full_sum;

    assign nib_sum = {1'b0, a_i[`CSSX_LO_NIB]} + {1'b0, b_i[`CSSX_LO_NIB]}
                     + {{`CSSX_NIB_W{1'b0}}, cin_i};
    assign full_sum = {1'b0, a_i} + {1'b0, b_i} + {{`CSSX_DW{1'b0}}, cin_i};
    assign sum_o = full_sum[`CSSX_DW-1:0];
    assign c_o = full_sum[`CSSX_DW];
    assign ac_o = nib_sum[`CSSX_NIB_W];
    // Like-signed operands giving an opposite-signed sum
    assign ovf_o = (a_i[`CSSX_DW-1] == b_i[`CSSX_DW-1])
                  & (sum_o[`CSSX_DW-1] != a_i[`CSSX_DW-1]);
endmodule // cssx_alu

`default_nettype wire

// file: cssx_dmem.v
// Small data memory: one synchronous write port, two combinational read ports.
// Assumes a single clock; contents are not cleared by reset, as in real RAM.
`timescale 1ns/1ns
`default_nettype none
`include "cssx_consts.vh"

module cssx_dmem #(
    parameter AW = 5,
    parameter DEPTH = 32
) (
    input wire clk_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [`CSSX_DW-1:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output wire [`CSSX_DW-1:0] rdata_o,
    input wire [AW-1:0] raddr2_i,
    output wire [`CSSX_DW-1:0] rdata2_o
);
    // Storage array
    reg [`CSSX_DW-1:0] mem_r [0:DEPTH-1];

    // Write on the clock edge
    always @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Read ports see the old value in a write cycle
    assign rdata_o = mem_r[raddr_i];
    assign rdata2_o = mem_r[raddr2_i];
endmodule // cssx_dmem

`default_nettype wire

// file: cssx_core.v
// Execution core for skip, subtract, nibble swap, xor and table-read operations.
// Assumes a sequencer on the same clock issues one operation per accepted cycle
// and that program memory answers a table read in the same cycle as the request.
`timescale 1ns/1ns
`default_nettype none
`include "cssx_consts.vh"

module cssx_core #(
    parameter AW = 5,
    parameter DEPTH = 32,
    parameter PM_AW = 10,
    parameter TP_W = 8,
    parameter PW_W = 14
) (
    input wire clk_i,
    input wire srst_i,
    input wire op_valid_i,
    input wire [`CSSX_OP_W-1:0] op_code_i,
    input wire [AW-1:0] op_addr_i,
    input wire [2:0] op_bit_i,
    input wire [`CSSX_DW-1:0] op_imm_i,
    input wire [PM_AW-1:0] pc_i,
    input wire [TP_W-1:0] table_pointer_i,
    input wire [PW_W-1:0] pm_data_i,
    input wire ext_mem_we_i,
    input wire ext_acc_we_i,
    input wire [AW-1:0] ext_addr_i,
    input wire [`CSSX_DW-1:0] ext_wdata_i,
    output reg op_ready_o,
    output reg done_o,
    output reg skip_o,
    output reg dummy_o,
    output reg [`CSSX_DW-1:0] acc_o,
    output reg signed_range_flag_o,
    output reg zero_flag_o,
    output reg aux_carry_o,
    output reg carry_o,
    output reg [PW_W-TP_W-1:0] table_high_byte_o,
    output reg pm_rd_o,
    output reg [PM_AW-1:0] pm_addr_o,
    output reg [`CSSX_DW-1:0] mem_q_o
);
    // Page field of a program address
    // An all-ones page field selects the last program page
    localparam PG_W = PM_AW - TP_W;

    // True when a byte is all zero
    function is_zero;
        input [`CSSX_DW-1:0] v;
        begin
            is_zero = (v == `CSSX_ZERO_BYTE);
        end
    endfunction

    // Machine state
    reg [`CSSX_ST_W-1:0] state_r;
    reg [`CSSX_ST_W-1:0] state_nxt;
    // Data memory address held across a table read
    reg [AW-1:0] tab_addr_r;
    reg [AW-1:0] tab_addr_nxt;
    // Next values of registered outputs
    reg [`CSSX_DW-1:0] acc_nxt;
    reg ovf_nxt;
    reg z_nxt;
    reg ac_nxt;
    reg c_nxt;
    reg skip_nxt;
    reg done_nxt;
    reg ready_nxt;
    reg tab_nxt;
    reg [PM_AW-1:0] pm_addr_nxt;
    reg [PW_W-TP_W-1:0] thb_nxt;
    // Memory write port controls
    reg mem_we;
    reg [AW-1:0] mem_wa;
    reg [`CSSX_DW-1:0] mem_wd;

    // Operation accepted this cycle
    wire take;
    // Operand byte from data memory
    wire [`CSSX_DW-1:0] mem_rd;
    wire [`CSSX_DW-1:0] mem_rd2;
    // Adder hookup
    wire inc_op;
    wire [`CSSX_DW-1:0] alu_a;
    wire [`CSSX_DW-1:0] alu_b;
    wire [`CSSX_DW-1:0] alu_sum;
    wire alu_c;
    wire alu_ac;
    wire alu_ovf;
    // Nibble-exchanged and xor results
    wire [`CSSX_DW-1:0] swapped;
    wire [`CSSX_DW-1:0] xor_mem;
    wire [`CSSX_DW-1:0] xor_imm;
    // Bit picked by the bit tests
    wire sel_bit;

    assign take = op_valid_i & op_ready_o;
    // Increments share the adder but must leave every flag alone
    assign inc_op = (op_code_i == `CSSX_OP_INCR_SKIP_ZERO)
                    | (op_code_i == `CSSX_OP_INCR_TO_A_SKIP);
    // Increment is byte plus zero plus carry in; subtract is acc plus inverse plus one
    assign alu_a = inc_op ? mem_rd : acc_o;
    assign alu_b = inc_op ? `CSSX_ZERO_BYTE
                 : (op_code_i == `CSSX_OP_SUB_IMM) ? ~op_imm_i : ~mem_rd;
    assign swapped = {mem_rd[`CSSX_LO_NIB], mem_rd[`CSSX_HI_NIB]};
    assign xor_mem = acc_o ^ mem_rd;
    assign xor_imm = acc_o ^ op_imm_i;
    assign sel_bit = mem_rd[op_bit_i];

    // Shared adder for increments and subtracts
    cssx_alu u_alu (
        .a_i(alu_a),
        .b_i(alu_b),
        .cin_i(`CSSX_ONE_BIT),
        .sum_o(alu_sum),
        .c_o(alu_c),
        .ac_o(alu_ac),
        .ovf_o(alu_ovf)
    );

    // Data memory; second read port serves the observation output
    cssx_dmem #(
        .AW(AW),
        .DEPTH(DEPTH)
    ) u_dmem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(mem_wa),
        .wdata_i(mem_wd),
        .raddr_i(op_addr_i),
        .rdata_o(mem_rd),
        .raddr2_i(ext_addr_i),
        .rdata2_o(mem_rd2)
    );

    // Decode and execute
    always @* begin
        state_nxt = state_r;
        tab_addr_nxt = tab_addr_r;
        acc_nxt = acc_o;
        ovf_nxt = signed_range_flag_o;
        z_nxt = zero_flag_o;
        ac_nxt = aux_carry_o;
        c_nxt = carry_o;
        skip_nxt = 1'b0;
        done_nxt = 1'b0;
        ready_nxt = op_ready_o;
        tab_nxt = 1'b0;
        pm_addr_nxt = pm_addr_o;
        thb_nxt = table_high_byte_o;
        mem_we = 1'b0;
        mem_wa = op_addr_i;
        mem_wd = alu_sum;
        case (state_r)
            `CSSX_ST_EXEC: begin
                if (take) begin
                    done_nxt = 1'b1;
                    case (op_code_i)
                        `CSSX_OP_INCR_SKIP_ZERO: begin
                            mem_we = 1'b1;
                            skip_nxt = is_zero(alu_sum);
                        end
                        `CSSX_OP_INCR_TO_A_SKIP: begin
                            acc_nxt = alu_sum;
                            skip_nxt = is_zero(alu_sum);
                        end
                        `CSSX_OP_BIT_SET_SKIP: begin
                            skip_nxt = sel_bit;
                        end
                        `CSSX_OP_SUB_MEM, `CSSX_OP_SUB_IMM: begin
                            acc_nxt = alu_sum;
                            ovf_nxt = alu_ovf;
                            z_nxt = is_zero(alu_sum);
                            ac_nxt = alu_ac;
                            c_nxt = alu_c;
                        end
                        `CSSX_OP_MINUS_TO_MEMORY: begin
                            mem_we = 1'b1;
                            ovf_nxt = alu_ovf;
                            z_nxt = is_zero(alu_sum);
                            ac_nxt = alu_ac;
                            c_nxt = alu_c;
                        end
                        `CSSX_OP_NIBBLE_FLIP: begin
                            mem_we = 1'b1;
                            mem_wd = swapped;
                        end
                        `CSSX_OP_NIBBLE_FLIP_TO_A: begin
                            acc_nxt = swapped;
                        end
                        `CSSX_OP_ZERO_SKIP: begin
                            skip_nxt = is_zero(mem_rd);
                        end
                        `CSSX_OP_MOVE_SKIP_ZERO: begin
                            acc_nxt = mem_rd;
                            skip_nxt = is_zero(mem_rd);
                        end
                        `CSSX_OP_BIT_CLEAR_SKIP: begin
                            skip_nxt = ~sel_bit;
                        end
                        `CSSX_OP_TABLE_READ_CUR_PAGE: begin
                            // Page bits of the running program counter
                            pm_addr_nxt = {pc_i[PM_AW-1:TP_W], table_pointer_i};
                            tab_nxt = 1'b1;
                            done_nxt = 1'b0;
                            ready_nxt = 1'b0;
                            tab_addr_nxt = op_addr_i;
                            state_nxt = `CSSX_ST_TABLE;
                        end
                        `CSSX_OP_TABLE_READ_LAST_PAGE: begin
                            // Highest page, whatever the program counter says
                            pm_addr_nxt = {{PG_W{1'b1}}, table_pointer_i};
                            tab_nxt = 1'b1;
                            done_nxt = 1'b0;
                            ready_nxt = 1'b0;
                            tab_addr_nxt = op_addr_i;
                            state_nxt = `CSSX_ST_TABLE;
                        end
                        `CSSX_OP_XOR_MEM: begin
                            acc_nxt = xor_mem;
                            z_nxt = is_zero(xor_mem);
                        end
                        `CSSX_OP_EXCLUSIVE_OR_TO_MEM: begin
                            mem_we = 1'b1;
                            mem_wd = xor_mem;
                            z_nxt = is_zero(xor_mem);
                        end
                        `CSSX_OP_XOR_IMM: begin
                            acc_nxt = xor_imm;
                            z_nxt = is_zero(xor_imm);
                        end
                        default: begin
                            done_nxt = 1'b1;
                        end
                    endcase
                    // Taken skip throws away the prefetch and costs one dummy cycle
                    if (skip_nxt) begin
                        ready_nxt = 1'b0;
                        state_nxt = `CSSX_ST_DUMMY;
                    end
                end else begin
                    // Side-door loads only when no operation is accepted
                    // Lets the bench preset operands with no load operation
                    if (ext_acc_we_i) begin
                        acc_nxt = ext_wdata_i;
                    end
                    if (ext_mem_we_i) begin
                        mem_we = 1'b1;
                        mem_wa = ext_addr_i;
                        mem_wd = ext_wdata_i;
                    end
                end
            end
            `CSSX_ST_DUMMY: begin
                // Dummy cycle over; the correct next operation may be issued
                ready_nxt = 1'b1;
                state_nxt = `CSSX_ST_EXEC;
            end
            `CSSX_ST_TABLE: begin
                // Program word arrives now; split it between memory and high byte
                mem_we = 1'b1;
                mem_wa = tab_addr_r;
                // Word must already stand on pm_data_i in this cycle
                mem_wd = pm_data_i[`CSSX_TAB_LO];
                thb_nxt = pm_data_i[`CSSX_TAB_HI];
                done_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = `CSSX_ST_EXEC;
            end
            default: begin
                // Unused code recovers to execute
                ready_nxt = 1'b1;
                state_nxt = `CSSX_ST_EXEC;
            end
        endcase
    end

    // State and output registers
    always @(posedge clk_i) begin
        if (srst_i) begin
            // Memory contents survive reset; only registers clear
            state_r <= `CSSX_ST_EXEC;
            tab_addr_r <= {AW{1'b0}};
            op_ready_o <= 1'b1;
            done_o <= 1'b0;
            skip_o <= 1'b0;
            dummy_o <= 1'b0;
            acc_o <= `CSSX_ACC_RST;
            signed_range_flag_o <= `CSSX_FLAG_RST;
            zero_flag_o <= `CSSX_FLAG_RST;
            aux_carry_o <= `CSSX_FLAG_RST;
            carry_o <= `CSSX_FLAG_RST;
            table_high_byte_o <= `CSSX_TABLE_HIGH_RST;
            pm_rd_o <= 1'b0;
            pm_addr_o <= {PM_AW{1'b0}};
            mem_q_o <= `CSSX_ZERO_BYTE;
        end else begin
            state_r <= state_nxt;
            tab_addr_r <= tab_addr_nxt;
            // Without a skip or table read, ready stays high: one cycle per operation
            op_ready_o <= ready_nxt;
            done_o <= done_nxt;
            skip_o <= skip_nxt;
            dummy_o <= skip_nxt;
            acc_o <= acc_nxt;
            signed_range_flag_o <= ovf_nxt;
            zero_flag_o <= z_nxt;
            aux_carry_o <= ac_nxt;
            carry_o <= c_nxt;
            table_high_byte_o <= thb_nxt;
            pm_rd_o <= tab_nxt;
            pm_addr_o <= pm_addr_nxt;
            // Registered view of the observed memory byte
            mem_q_o <= mem_rd2;
        end
    end
endmodule // cssx_core

`default_nettype wire

// file: cssx_core_asserts.sv
// Concurrent checks on the ports of the skip / subtract / xor / table-read core.
// Assumes one clock and a synchronous active-high reset; bound at the file foot.
`timescale 1ns/1ns
`default_nettype none
`include "cssx_consts.vh"

module cssx_core_chk #(
    parameter PM_AW = 10,
    parameter TP_W = 8,
    parameter PW_W = 14
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic op_valid_i,
    input wire logic [`CSSX_OP_W-1:0] op_code_i,
    input wire logic [`CSSX_DW-1:0] op_imm_i,
    input wire logic [PM_AW-1:0] pc_i,
    input wire logic [TP_W-1:0] table_pointer_i,
    input wire logic [PW_W-1:0] pm_data_i,
    input wire logic op_ready_o,
    input wire logic done_o,
    input wire logic skip_o,
    input wire logic dummy_o,
    input wire logic [`CSSX_DW-1:0] acc_o,
    input wire logic zero_flag_o,
    input wire logic carry_o,
    input wire logic [PW_W-TP_W-1:0] table_high_byte_o,
    input wire logic pm_rd_o,
    input wire logic [PM_AW-1:0] pm_addr_o
);
    // Accepted request and whether it is a table read
    wire logic take = op_valid_i && op_ready_o;
    wire logic tbl = op_code_i == `CSSX_OP_TABLE_READ_CUR_PAGE
        || op_code_i == `CSSX_OP_TABLE_READ_LAST_PAGE;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Plain ops finish one cycle after the take
    chk_done_next: assert property (take && !tbl |=> done_o)
        else $error("done not one cycle after take");
    // Skip cycle is the dummy cycle and blocks the next take
    chk_skip_dummy: assert property (skip_o |-> dummy_o && done_o && !op_ready_o)
        else $error("skip without dummy cycle");
    chk_skip_recover: assert property (skip_o |=> op_ready_o && !done_o && !dummy_o)
        else $error("no recovery after dummy cycle");
    chk_incr_acc: assert property (take && op_code_i == `CSSX_OP_INCR_TO_A_SKIP
        |=> skip_o == (acc_o == 8'h00)) else $error("incr to acc skip wrong");
    chk_move_skip: assert property (take && op_code_i == `CSSX_OP_MOVE_SKIP_ZERO
        |=> skip_o == (acc_o == 8'h00)) else $error("move skip wrong");
    // Xor of immediate keeps carry, sets zero from result
    chk_xor_imm: assert property (take && op_code_i == `CSSX_OP_XOR_IMM
        |=> acc_o == ($past(acc_o) ^ $past(op_imm_i)) && zero_flag_o == (acc_o == 8'h00)
        && carry_o == $past(carry_o)) else $error("xor immediate wrong");
    chk_sub_imm: assert property (take && op_code_i == `CSSX_OP_SUB_IMM
        |=> acc_o == $past(acc_o) - $past(op_imm_i)
        && carry_o == ($past(acc_o) >= $past(op_imm_i))) else $error("sub immediate wrong");
    // Table read: request in cycle 1, done in cycle 2
    chk_table_seq: assert property (take && tbl |=> pm_rd_o && !op_ready_o ##1 done_o)
        else $error("table read sequence wrong");
    chk_cur_page: assert property (take && op_code_i == `CSSX_OP_TABLE_READ_CUR_PAGE
        |=> pm_addr_o == {$past(pc_i[PM_AW-1:TP_W]), $past(table_pointer_i)})
        else $error("current page address wrong");
    chk_last_page: assert property (take && op_code_i == `CSSX_OP_TABLE_READ_LAST_PAGE
        |=> pm_addr_o == {{(PM_AW-TP_W){1'b1}}, $past(table_pointer_i)})
        else $error("last page address wrong");
    chk_table_high: assert property (pm_rd_o
        |=> table_high_byte_o == $past(pm_data_i[PW_W-1:TP_W])) else $error("high byte wrong");
endmodule // cssx_core_chk

bind cssx_core cssx_core_chk #(.PM_AW(PM_AW), .TP_W(TP_W), .PW_W(PW_W)) cssx_core_chk_i (
    .clk_i, .srst_i, .op_valid_i, .op_code_i, .op_imm_i, .pc_i, .table_pointer_i,
    .pm_data_i, .op_ready_o, .done_o, .skip_o, .dummy_o, .acc_o, .zero_flag_o,
    .carry_o, .table_high_byte_o, .pm_rd_o, .pm_addr_o);
`default_nettype wire

// file: tb_cpu_skip_sub_swap_xor_table_ops.sv
// Self-checking bench for the skip / subtract / swap / xor / table-read core.
// Assumes default core parameters; memory is preset and read through the side port.
`timescale 1ns/1ns
`default_nettype none
`include "cssx_consts.vh"

module tb_cpu_skip_sub_swap_xor_table_ops;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic op_valid_i = 1'b0, ext_mem_we_i = 1'b0, ext_acc_we_i = 1'b0;
    logic [3:0] op_code_i = 4'h0;
    logic [4:0] op_addr_i = 5'h00, ext_addr_i = 5'h00;
    logic [2:0] op_bit_i = 3'h0;
    logic [7:0] op_imm_i = 8'h00, ext_wdata_i = 8'h00, table_pointer_i = 8'h00;
    logic [9:0] pc_i = 10'h000;
    logic [13:0] pm_data_i = 14'h0000;
    logic op_ready_o, done_o, skip_o, dummy_o, pm_rd_o;
    logic signed_range_flag_o, zero_flag_o, aux_carry_o, carry_o;
    logic [7:0] acc_o, mem_q_o;
    logic [5:0] table_high_byte_o;
    logic [9:0] pm_addr_o;
    integer errors = 0;
    integer num_checks = 0;
    // Flags packed as {overflow, zero, aux, carry}
    wire [7:0] flags = {4'h0, signed_range_flag_o, zero_flag_o, aux_carry_o, carry_o};

    cssx_core cssx_core_i (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .op_addr_i(op_addr_i), .op_bit_i(op_bit_i),
        .op_imm_i(op_imm_i), .pc_i(pc_i), .table_pointer_i(table_pointer_i),
        .pm_data_i(pm_data_i), .ext_mem_we_i(ext_mem_we_i), .ext_acc_we_i(ext_acc_we_i),
        .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i), .op_ready_o(op_ready_o),
        .done_o(done_o), .skip_o(skip_o), .dummy_o(dummy_o), .acc_o(acc_o),
        .signed_range_flag_o(signed_range_flag_o), .zero_flag_o(zero_flag_o),
        .aux_carry_o(aux_carry_o), .carry_o(carry_o), .table_high_byte_o(table_high_byte_o),
        .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .mem_q_o(mem_q_o));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Reference subtract: a + ~b + 1, giving {overflow, zero, aux, carry, result}
    function automatic [11:0] subf(input [7:0] a, input [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        subf = {(a[7] == ~b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    // Side port writes; a write is taken only while no op is issued
    task set_mem(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        ext_mem_we_i <= 1'b1; ext_addr_i <= a; ext_wdata_i <= d;
        @(posedge clk_i);
        ext_mem_we_i <= 1'b0;
    endtask

    task set_acc(input logic [7:0] d);
        @(posedge clk_i);
        ext_acc_we_i <= 1'b1; ext_wdata_i <= d;
        @(posedge clk_i);
        ext_acc_we_i <= 1'b0;
    endtask

    // Memory seen one edge after the address is presented
    task rd_mem(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_i);
        ext_addr_i <= a;
        @(posedge clk_i);
        #1 chk8(mem_q_o, e, "memory byte");
    endtask

    // Issue one op, wait bounded for done, judge latency and skip
    task run_op(input logic [3:0] c, input logic [4:0] a, input logic [2:0] b,
                input logic [7:0] x, input logic s);
        integer n;
        n = 0;
        @(posedge clk_i);
        op_valid_i <= 1'b1; op_code_i <= c; op_addr_i <= a; op_bit_i <= b; op_imm_i <= x;
        #1;
        while (op_ready_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1 n = n + 1;
        end
        if (op_ready_o !== 1'b1) begin
            chk8(8'h00, 8'h01, "never ready");
            close_out;
        end
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1 n = 1;
        while (done_o !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1 n = n + 1;
        end
        chk8(n[7:0], (c == `CSSX_OP_TABLE_READ_CUR_PAGE || c == `CSSX_OP_TABLE_READ_LAST_PAGE)
            ? 8'h02 : 8'h01, "latency");
        chk8({skip_o, dummy_o}, {s, s}, "skip and dummy");
        if (done_o !== 1'b1) close_out;
    endtask

    task t_incr;
        set_mem(5'h01, 8'hFF);
        run_op(`CSSX_OP_INCR_SKIP_ZERO, 5'h01, 3'h0, 8'h00, 1'b1);
        rd_mem(5'h01, 8'h00);
        set_mem(5'h02, 8'h05);
        run_op(`CSSX_OP_INCR_SKIP_ZERO, 5'h02, 3'h0, 8'h00, 1'b0);
        rd_mem(5'h02, 8'h06);
        run_op(`CSSX_OP_INCR_TO_A_SKIP, 5'h01, 3'h0, 8'h00, 1'b0);
        chk8(acc_o, 8'h01, "incr to acc");
        set_mem(5'h03, 8'hFF);
        run_op(`CSSX_OP_INCR_TO_A_SKIP, 5'h03, 3'h0, 8'h00, 1'b1);
        chk8(acc_o, 8'h00, "incr to acc wrap");
        rd_mem(5'h03, 8'hFF);
    endtask

    // Every bit position tested both ways
    task t_bits;
        set_mem(5'h04, 8'hA5);
        for (int i = 0; i < 8; i++) begin
            run_op(`CSSX_OP_BIT_SET_SKIP, 5'h04, i[2:0], 8'h00, 8'hA5 >> i);
            run_op(`CSSX_OP_BIT_CLEAR_SKIP, 5'h04, i[2:0], 8'h00, ~(8'hA5 >> i));
        end
    endtask

    task t_zero;
        set_mem(5'h06, 8'h00);
        run_op(`CSSX_OP_ZERO_SKIP, 5'h06, 3'h0, 8'h00, 1'b1);
        set_acc(8'h77);
        run_op(`CSSX_OP_MOVE_SKIP_ZERO, 5'h06, 3'h0, 8'h00, 1'b1);
        chk8(acc_o, 8'h00, "move zero");
        set_mem(5'h06, 8'h81);
        run_op(`CSSX_OP_ZERO_SKIP, 5'h06, 3'h0, 8'h00, 1'b0);
        run_op(`CSSX_OP_MOVE_SKIP_ZERO, 5'h06, 3'h0, 8'h00, 1'b0);
        chk8(acc_o, 8'h81, "move nonzero");
    endtask

    // Borrow, overflow, zero and nibble-borrow corners for all three forms
    task t_sub;
        logic [7:0] va [4] = '{8'h50, 8'hA0, 8'h00, 8'h80};
        logic [7:0] vb [4] = '{8'hB0, 8'hA0, 8'h01, 8'h01};
        logic [11:0] r;
        for (int i = 0; i < 4; i++) begin
            r = subf(va[i], vb[i]);
            set_acc(va[i]);
            set_mem(5'h08, vb[i]);
            run_op(`CSSX_OP_SUB_MEM, 5'h08, 3'h0, 8'h00, 1'b0);
            chk8(acc_o, r[7:0], "sub mem");
            chk8(flags, {4'h0, r[11:8]}, "sub mem flags");
            set_acc(va[i]);
            run_op(`CSSX_OP_SUB_IMM, 5'h00, 3'h0, vb[i], 1'b0);
            chk8(acc_o, r[7:0], "sub imm");
            chk8(flags, {4'h0, r[11:8]}, "sub imm flags");
            set_acc(va[i]);
            run_op(`CSSX_OP_MINUS_TO_MEMORY, 5'h08, 3'h0, 8'h00, 1'b0);
            chk8(flags, {4'h0, r[11:8]}, "sub to mem flags");
            chk8(acc_o, va[i], "sub to mem acc");
            rd_mem(5'h08, r[7:0]);
        end
    endtask

    task t_swap;
        set_mem(5'h09, 8'h3C);
        run_op(`CSSX_OP_NIBBLE_FLIP, 5'h09, 3'h0, 8'h00, 1'b0);
        rd_mem(5'h09, 8'hC3);
        run_op(`CSSX_OP_NIBBLE_FLIP_TO_A, 5'h09, 3'h0, 8'h00, 1'b0);
        chk8(acc_o, 8'h3C, "swap to acc");
        rd_mem(5'h09, 8'hC3);
    endtask

    // Only the zero flag may move on xor
    task t_xor;
        logic [7:0] f;
        f = flags & 8'hFB;
        set_acc(8'h5A);
        set_mem(5'h0A, 8'h5A);
        run_op(`CSSX_OP_XOR_MEM, 5'h0A, 3'h0, 8'h00, 1'b0);
        chk8(acc_o, 8'h00, "xor mem");
        chk8(flags, f | 8'h04, "xor mem flags");
        set_acc(8'h3C);
        set_mem(5'h0A, 8'h0F);
        run_op(`CSSX_OP_EXCLUSIVE_OR_TO_MEM, 5'h0A, 3'h0, 8'h00, 1'b0);
        chk8(flags, f, "xor to mem flags");
        chk8(acc_o, 8'h3C, "xor to mem acc");
        rd_mem(5'h0A, 8'h33);
        run_op(`CSSX_OP_XOR_IMM, 5'h00, 3'h0, 8'h3C, 1'b0);
        chk8(flags, f | 8'h04, "xor imm flags");
        chk8(acc_o, 8'h00, "xor imm");
    endtask

    task t_table;
        @(posedge clk_i);
        pc_i <= 10'h2A5; table_pointer_i <= 8'h33; pm_data_i <= 14'h2B96;
        run_op(`CSSX_OP_TABLE_READ_CUR_PAGE, 5'h0B, 3'h0, 8'h00, 1'b0);
        chk8({6'h00, pm_addr_o[9:8]}, 8'h02, "cur page");
        chk8(pm_addr_o[7:0], 8'h33, "pointer");
        chk8({2'h0, table_high_byte_o}, 8'h2B, "high byte");
        rd_mem(5'h0B, 8'h96);
        @(posedge clk_i);
        pm_data_i <= 14'h1C01;
        run_op(`CSSX_OP_TABLE_READ_LAST_PAGE, 5'h0C, 3'h0, 8'h00, 1'b0);
        chk8({6'h00, pm_addr_o[9:8]}, 8'h03, "last page");
        chk8(pm_addr_o[7:0], 8'h33, "last pointer");
        chk8({2'h0, table_high_byte_o}, 8'h1C, "last high byte");
        rd_mem(5'h0C, 8'h01);
    endtask

    // Reset for five cycles, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        #1 chk8({op_ready_o, acc_o[6:0]}, 8'h80, "reset state");
        chk8(flags, 8'h00, "reset flags");
        chk8({2'h0, table_high_byte_o}, 8'h00, "reset high byte");
        t_incr;
        t_bits;
        t_zero;
        t_sub;
        t_swap;
        t_xor;
        t_table;
        close_out;
    end
endmodule // tb_cpu_skip_sub_swap_xor_table_ops
`default_nettype wire
